// ===== bench/maf_filter_asserts.sv
// Purpose: Port checks of the averaging filter
// Assumes: One clock, reset low active
// Notes: Bound to the filter top
`timescale 1ns/100ps
module maf_filter_asserts
    import maf_pkg::*;
#(parameter int DW = 16, parameter logic [DW-1:0] ERR_VALUE = '1) (
    input wire logic clock_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, // Bus
    input wire logic [7:0] avs_address_in, // Address
    input wire logic [31:0] avs_readdata_out, // Read data
    input wire logic sample_valid_in, out_valid_out, out_error_out, nvm_store_out, // Pulses, except out_error_out, a flag held until the next output
    input wire logic [DW-1:0] out_data_out // Value
);
    // ==========================================================
    // Bus, stream and save checks
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("stall too long");
    AST_WAIT_BACK: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("stall not back");
    AST_UNMAPPED: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h1C |-> !avs_readdata_out)
        else $error("unmapped read not zero");
    AST_OUT_LAT: assert property (out_valid_out |-> $past(sample_valid_in, 4))
        else $error("output without sample");
    AST_OUT_PULSE: assert property (out_valid_out |=> !out_valid_out)
        else $error("output pulse too long");
    AST_OUT_HOLD: assert property (!out_valid_out |-> $stable(out_data_out) && $stable(out_error_out))
        else $error("output changed between pulses");
    AST_ERR_CODE: assert property (out_error_out |-> out_data_out == ERR_VALUE)
        else $error("error flag without code");
    AST_SAVE_CAUSE: assert property (nvm_store_out |-> $past(avs_write_in && avs_address_in == MAF_REG_SAVE))
        else $error("save without write");
    AST_SAVE_PULSE: assert property (nvm_store_out |=> !nvm_store_out)
        else $error("save pulse too long");
    cover property (out_valid_out && out_error_out);
    cover property (out_valid_out && !out_error_out);
    cover property (nvm_store_out);
endmodule
bind maf_filter maf_filter_asserts #(.DW(DW), .ERR_VALUE(ERR_VALUE)) i_maf_filter_asserts (.clock_in, .rst_n_in,
    .avs_read_in, .avs_write_in, .avs_waitrequest_out, .avs_address_in, .avs_readdata_out, .sample_valid_in,
    .out_valid_out, .out_error_out, .nvm_store_out, .out_data_out);

// ===== bench/maf_host_model.sv
// Purpose: Host taking released values
// Assumes: Pulses on the filter clock
// Notes: Counts values so the bench sees arrivals
`timescale 1ns/100ps
module maf_host_model (
    input wire logic clock_in, // Clock
    input wire logic val_in, // Value pulse
    input wire logic [16:0] data_in, // Error flag and value
    output int got_out = 0, // Values taken
    output logic [16:0] last_out // Last taken
);
    // ==========================================================
    // One value per pulse, nothing between pulses
    always @(posedge clock_in) begin
        if (val_in) begin
            got_out <= got_out + 1;
            last_out <= data_in;
        end
    end
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench of the filter
// Assumes: Samples far apart
// Notes: One task per scenario
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
    import maf_pkg::*;
    logic clock_in = 0, rst_n_in = 0, rd = 0, wr = 0, sv = 0, ok = 0, trig = 0, ld = 0, wreq, ov, oe, ae;
    logic [33:0] nd;
    logic [7:0] ad = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [15:0] sd = 0, od;
    logic [16:0] last;
    int fails = 0, checked = 0, got, n;
    // ==========================================================
    // Clock, filter and host
    always #20 clock_in = ~clock_in;
    maf_filter i_maf_filter (.clock_in, .rst_n_in, .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .sample_valid_in(sv), .sample_data_in(sd), .sample_ok_in(ok), .trig_pin_in(trig), .nvm_load_in(ld),
        .nvm_data_in(nd), .nvm_store_out(), .nvm_data_out(nd), .out_valid_out(ov), .out_data_out(od),
        .out_error_out(oe), .analog_error_out(ae));
    maf_host_model i_maf_host_model (.clock_in, .val_in(ov), .data_in({oe, od}), .got_out(got), .last_out(last));
    // Held until waitrequest is seen low, so no wait count is assumed
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {wr, rd, ad, wd} <= {w, !w, a, d};
        do @(posedge clock_in); while (wreq !== 1'b0);
        q = rdat;
        {wr, rd} <= 2'b00;
        @(posedge clock_in);
    endtask
    // One sample, then the fixed four-edge latency plus margin
    task s(input logic [15:0] d, input logic k, input logic [17:0] e);
        n = got;
        {sv, sd, ok} <= {1'b1, d, k};
        @(posedge clock_in);
        sv <= 1'b0;
        repeat (6) @(posedge clock_in);
        `CHK(got != n ? {1'b1, last} : 18'h0, e)
    endtask
    task t_cfg;
        bus(1'b0, MAF_REG_AVG1, 32'h0);
        `CHK(q, 32'h30009)
        bus(1'b0, 8'h1C, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b1, MAF_REG_AVG1, 32'h0);
        s(16'h1234, 1'b1, 18'h21234);
        bus(1'b1, MAF_REG_AVG1, 32'h10002);
        s(16'h10, 1'b1, 18'h20010);
        s(16'h20, 1'b1, 18'h20018);
        bus(1'b1, MAF_REG_AVG1, 32'h10003);
        bus(1'b0, MAF_REG_AVG1, 32'h0);
        `CHK(q, 32'h10002)
        bus(1'b1, MAF_REG_AVG2, 32'h10002);
        s(16'h30, 1'b1, 18'h20030);
        s(16'h50, 1'b1, 18'h20038);
        bus(1'b1, MAF_REG_AVG2, 32'h0);
        bus(1'b1, MAF_REG_AVG1, 32'h20002);
        s(16'h10, 1'b1, 18'h20010);
        s(16'h20, 1'b1, 18'h20018);
        bus(1'b1, MAF_REG_AVG1, 32'h30003);
        s(16'h9, 1'b1, 18'h20009);
        s(16'h5, 1'b1, 18'h20005);
        s(16'h7, 1'b1, 18'h20007);
        bus(1'b1, MAF_REG_SAVE, 32'h0);
        `CHK(nd, 34'h18003)
        bus(1'b1, MAF_REG_AVG1, 32'h0);
        ld <= 1'b1;
        @(posedge clock_in);
        ld <= 1'b0;
        bus(1'b0, MAF_REG_AVG1, 32'h0);
        `CHK(q, 32'h30003)
        bus(1'b1, MAF_REG_AVG1, 32'h0);
        $display("t_cfg done");
    endtask
    task t_err;
        s(16'h5, 1'b0, 18'h3FFFF);
        `CHK(ae, 1'b1)
        bus(1'b1, MAF_REG_CTRL, 32'h4);
        s(16'h6, 1'b1, 18'h20006);
        s(16'h7, 1'b0, 18'h20006);
        bus(1'b1, MAF_REG_CTRL, 32'h8);
        s(16'h8, 1'b1, 18'h20008);
        s(16'h9, 1'b0, 18'h20008);
        s(16'h9, 1'b0, 18'h3FFFF);
        $display("t_err done");
    endtask
    task t_trig;
        bus(1'b1, MAF_REG_CTRL, 32'h3);
        bus(1'b0, MAF_REG_CTRL, 32'h0);
        `CHK(q[1:0], 2'b01)
        bus(1'b1, MAF_REG_CTRL, 32'h2);
        bus(1'b0, MAF_REG_CTRL, 32'h0);
        `CHK(q[1:0], 2'b10)
        s(16'h1, 1'b1, 18'h0);
        bus(1'b1, MAF_REG_CTRL, 32'h12);
        s(16'h2, 1'b1, 18'h20002);
        bus(1'b1, MAF_REG_CTRL, 32'h1);
        s(16'h3, 1'b1, 18'h0);
        trig <= 1'b1;
        repeat (6) @(posedge clock_in);
        s(16'h4, 1'b1, 18'h20004);
        $display("t_trig done");
    endtask
    task results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        t_cfg;
        t_err;
        t_trig;
        results;
    end
    initial begin
        #100000;
        fails++;
        results;
    end
endmodule

// ===== verilog/maf_filter.sv
// Purpose: Two-stage averaging and error handling for the distance value stream
// Assumes: One sample pulse per measurement cycle, far apart compared with the clock
// Notes: Dividers are combinational; timing at 25 MHz is the price for a small design
//
// How it works
// [RULE1] Record trigger flushes averaging; earlier samples are dropped.
// [RULE2] Setting record-trigger mode clears output-trigger mode.
// [RULE3] Setting output-trigger mode clears record-trigger mode.
// [RULE4] Output trigger only releases results; averaging keeps running.
// [RULE5] Error-value mode outputs the error code and analog error level.
// [RULE6] Infinite hold repeats the last valid value while samples stay invalid.
// [RULE7] Counted hold repeats last value 1..1024 times, then outputs error value.
// [RULE8] Stage one feeds stage two, a fixed cascade.
// [RULE9] Averaging sits between the distance input and the output port.
// [RULE10] An inactive stage passes samples through unchanged.
// [RULE11] Each sample yields a result; partial depth is used until N samples exist.
// [RULE12] Exactly one output per measurement, no rate change.
// [RULE13] After reset stage one is median over 9 samples.
// [RULE14] Moving mode keeps last N samples, sum divided by N.
// [RULE15] Moving depth only accepted as power of two, 1 to 4096.
// [RULE16] Recursive mode: (new + (N-1) * previous) / N.
// [RULE17] Recursive depth accepted from 1 to 32000.
// [RULE18] Recursive state starts from the first sample after flush or restart.
// [RULE19] Median mode sorts last N (3,5,7,9) samples and outputs the middle.
// [RULE20] Configuration saved to and loaded from non-volatile storage.
// [RULE21] Host programs depths through registers; legal settings apply.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.

`timescale 1ns/100ps

module maf_filter
    import maf_pkg::*;
#(
    parameter int DW = 16,                       // Distance value width
    parameter logic [DW-1:0] ERR_VALUE = '1      // Error code sent instead of a value
) (
    input wire logic clock_in,                   // 25 MHz clock
    input wire logic rst_n_in,                   // Async reset, active low
    input wire logic [7:0] avs_address_in,       // Byte address
    input wire logic avs_read_in,                // Read request
    input wire logic avs_write_in,               // Write request
    input wire logic [31:0] avs_writedata_in,    // Write data
    input wire logic [3:0] avs_byteenable_in,    // Byte lanes
    output logic [31:0] avs_readdata_out,        // Read data
    output logic avs_waitrequest_out,            // Stall
    input wire logic sample_valid_in,            // New distance value pulse
    input wire logic [DW-1:0] sample_data_in,    // Distance value
    input wire logic sample_ok_in,               // Value is a valid reading
    input wire logic trig_pin_in,                // Trigger pin, asynchronous
    input wire logic nvm_load_in,                // Stored configuration pulse
    input wire logic [MAF_NVM_W-1:0] nvm_data_in, // Stored configuration
    output logic nvm_store_out,                  // Save configuration pulse
    output logic [MAF_NVM_W-1:0] nvm_data_out,   // Configuration to save
    output logic out_valid_out,                  // Output value pulse
    output logic [DW-1:0] out_data_out,          // Output value or error code
    output logic out_error_out,                  // Output is the error code
    output logic analog_error_out                // Analog at fixed error level
);

    // ==========================================================
    // Helpers
    function automatic logic cfg_ok(input logic [1:0] typ, input logic [14:0] dep);
        logic ok;
        ok = 1'b0;
        case (maf_avg_t'(typ))
            MAF_AVG_OFF: ok = 1'b1;
            MAF_AVG_MOVING: ok = dep != 15'h0 && dep <= MAF_MOV_MAX && (dep & (dep - 15'h1)) == 15'h0; // RULE15
            MAF_AVG_RECURSIVE: ok = dep != 15'h0 && dep <= MAF_REC_MAX; // RULE17
            MAF_AVG_MEDIAN: ok = dep == 15'h3 || dep == 15'h5 || dep == 15'h7 || dep == 15'h9;   // RULE19
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // State declarations
    logic wait_q;
    logic [31:0] rdata_q;
    logic rec_en_q;
    logic out_en_q;
    logic [1:0] err_mode_q;
    logic [10:0] hold_cnt_q;
    logic [1:0] avg_type_q [0:MAF_STAGES-1];
    logic [14:0] avg_depth_q [0:MAF_STAGES-1];
    logic gate_q;
    logic flush_q;
    logic swtrig_q;
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic stg_v [0:MAF_STAGES];
    logic stg_ok [0:MAF_STAGES];
    logic [DW-1:0] stg_d [0:MAF_STAGES];
    logic [DW-1:0] last_q;
    logic have_last_q;
    logic [10:0] held_q;
    logic bus_wr;
    logic bus_rd;
    logic trig_event;
    logic [31:0] wr_img;
    logic [31:0] avg_img [0:MAF_STAGES-1];
    logic [31:0] avg_wr [0:MAF_STAGES-1];

    assign bus_wr = avs_write_in && !wait_q;
    assign bus_rd = avs_read_in && wait_q;
    assign trig_event = (trig_s2_q && !trig_s3_q) || swtrig_q;

    // Register images as software sees them
    always_comb begin
        for (int s = 0; s < MAF_STAGES; s++) begin
            avg_img[s] = 32'h0;
            avg_img[s][MAF_AVG_TYPE_LSB +: 2] = avg_type_q[s];
            avg_img[s][MAF_AVG_DEPTH_LSB +: MAF_DEPTH_W] = avg_depth_q[s];
            avg_wr[s] = be_merge(avg_img[s], avs_writedata_in, avs_byteenable_in);
        end
    end

    // ==========================================================
    // Avalon slave: request seen, one wait cycle, then completes
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_q <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data registered when the request is first seen; unmapped reads return zero
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0;
        end else if (bus_rd) begin
            case (avs_address_in)
                MAF_REG_CTRL: rdata_q <= {27'h0, 1'b0, err_mode_q, out_en_q, rec_en_q};
                MAF_REG_HOLD: rdata_q <= {21'h0, hold_cnt_q};
                MAF_REG_AVG1: rdata_q <= avg_img[0];
                MAF_REG_AVG2: rdata_q <= avg_img[1];
                MAF_REG_STATUS: rdata_q <= {29'h0, have_last_q, analog_error_out, gate_q};
                MAF_REG_RESULT: rdata_q <= 32'(out_data_out);
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;

    // Write image for CTRL with byte enables applied
    assign wr_img = be_merge({27'h0, 1'b0, err_mode_q, out_en_q, rec_en_q}, avs_writedata_in, avs_byteenable_in);

    // ==========================================================
    // Trigger mode and error mode control
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rec_en_q <= 1'b0;
            out_en_q <= 1'b0;
            err_mode_q <= 2'h0;
            swtrig_q <= 1'b0;
        end else begin
            swtrig_q <= bus_wr && avs_address_in == MAF_REG_CTRL && wr_img[MAF_CTRL_SWTRIG_BIT];
            if (bus_wr && avs_address_in == MAF_REG_CTRL) begin
                err_mode_q <= wr_img[MAF_CTRL_ERR_LSB +: 2];
                if (wr_img[MAF_CTRL_REC_BIT]) begin
                    rec_en_q <= 1'b1;
                    out_en_q <= 1'b0; // RULE2
                end else if (wr_img[MAF_CTRL_OUT_BIT]) begin
                    out_en_q <= 1'b1;
                    rec_en_q <= 1'b0; // RULE3
                end else begin
                    rec_en_q <= 1'b0;
                    out_en_q <= 1'b0;
                end
            end
        end
    end

    // Hold count; values outside 1..1024 are refused
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_cnt_q <= MAF_RST_HOLD;
        end else if (bus_wr && avs_address_in == MAF_REG_HOLD) begin
            if (avs_byteenable_in[1:0] == 2'h3 && avs_writedata_in[10:0] != 11'h0 &&
                avs_writedata_in[10:0] <= MAF_HOLD_MAX) begin
                hold_cnt_q <= avs_writedata_in[10:0];      // RULE7
            end
        end
    end

    // Averaging configuration; invalid type/depth pairs leave the old setting
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avg_type_q[0] <= MAF_RST_TYPE1; // RULE13
            avg_depth_q[0] <= MAF_RST_DEPTH1; // RULE13
            avg_type_q[1] <= MAF_RST_TYPE2;
            avg_depth_q[1] <= MAF_RST_DEPTH2;
        end else if (nvm_load_in) begin
            for (int s = 0; s < MAF_STAGES; s++) begin
                if (cfg_ok(nvm_data_in[s*MAF_CFG_W+MAF_DEPTH_W +: 2], nvm_data_in[s*MAF_CFG_W +: MAF_DEPTH_W])) begin
                    avg_type_q[s] <= nvm_data_in[s*MAF_CFG_W+MAF_DEPTH_W +: 2];   // RULE20
                    avg_depth_q[s] <= nvm_data_in[s*MAF_CFG_W +: MAF_DEPTH_W];
                end
            end
        end else if (bus_wr && (avs_address_in == MAF_REG_AVG1 || avs_address_in == MAF_REG_AVG2)) begin
            for (int s = 0; s < MAF_STAGES; s++) begin
                if (avs_address_in == (s == 0 ? MAF_REG_AVG1 : MAF_REG_AVG2)) begin
                    if (cfg_ok(avg_wr[s][MAF_AVG_TYPE_LSB +: 2], avg_wr[s][14:0])) begin
                        avg_type_q[s] <= avg_wr[s][17:16]; // RULE21
                        avg_depth_q[s] <= avg_wr[s][14:0];
                    end
                end
            end
        end
    end

    // Save request copies the live configuration out to storage
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nvm_store_out <= 1'b0;
            nvm_data_out <= '0;
        end else begin
            nvm_store_out <= bus_wr && avs_address_in == MAF_REG_SAVE; // RULE20
            if (bus_wr && avs_address_in == MAF_REG_SAVE) begin
                nvm_data_out <= {avg_type_q[1], avg_depth_q[1], avg_type_q[0], avg_depth_q[0]};
            end
        end
    end

    // ==========================================================
    // Trigger pin synchroniser; edge taken between second and third flop
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= trig_pin_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    // Gate opens on a trigger and closes when the mode is rewritten
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            flush_q <= (trig_event && rec_en_q) || nvm_load_in ||
                       (bus_wr && (avs_address_in == MAF_REG_AVG1 || avs_address_in == MAF_REG_AVG2));
            if (trig_event) begin
                gate_q <= 1'b1;
            end else if (bus_wr && avs_address_in == MAF_REG_CTRL) begin
                gate_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Input of the cascade; record mode drops everything before the trigger
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stg_v[0] <= 1'b0;
            stg_ok[0] <= 1'b0;
            stg_d[0] <= '0;
        end else begin
            stg_v[0] <= sample_valid_in && (!rec_en_q || gate_q) && !flush_q;   // RULE1 RULE9
            stg_ok[0] <= sample_ok_in;
            stg_d[0] <= sample_data_in;
        end
    end

    // ==========================================================
    // Averaging stages, stage s feeds stage s+1
    for (genvar gs = 0; gs < MAF_STAGES; gs++) begin : stage
        logic [DW-1:0] win_mem [0:(1<<MAF_MOV_AW)-1];
        logic [MAF_MOV_AW-1:0] wp_q;
        logic [14:0] cnt_q;
        logic [DW+12:0] sum_q;
        logic [DW-1:0] prev_q;
        logic [DW-1:0] tap_q [0:MAF_MED_TAPS-1];
        logic [DW-1:0] taps [0:MAF_MED_TAPS-1];
        logic [14:0] k;
        logic [DW+12:0] sum_new;
        logic [DW+15:0] rec_num;
        logic [DW-1:0] mov_res;
        logic [DW-1:0] rec_res;
        logic [DW-1:0] med_res;
        logic [DW-1:0] res;
        logic take;

        assign take = stg_v[gs] && stg_ok[gs] && maf_avg_t'(avg_type_q[gs]) != MAF_AVG_OFF;
        // Samples counted including the new one, capped at N
        assign k = (cnt_q < avg_depth_q[gs]) ? cnt_q + 15'h1 : avg_depth_q[gs]; // RULE11

        // Moving sum: add newest, drop oldest once the window is full
        assign sum_new = sum_q + (DW+13)'(stg_d[gs]) -
                         ((cnt_q >= avg_depth_q[gs]) ? (DW+13)'(win_mem[wp_q]) : '0); // RULE14
        assign mov_res = DW'(sum_new / (DW+13)'(k)); // RULE14
        // Recursive: with k = 1 the result is the first sample itself
        assign rec_num = (DW+16)'(stg_d[gs]) + (DW+16)'(k - 15'h1) * (DW+16)'(prev_q); // RULE16 RULE18
        assign rec_res = DW'(rec_num / (DW+16)'(k)); // RULE16

        // Median by rank counting over the newest k taps; ties broken by age
        always_comb begin
            logic [3:0] rank;
            logic [3:0] kk;
            rank = 4'h0;
            kk = 4'(k);
            taps[0] = stg_d[gs];
            for (int i = 1; i < MAF_MED_TAPS; i++) begin
                taps[i] = tap_q[i-1];
            end
            med_res = stg_d[gs];
            for (int i = 0; i < MAF_MED_TAPS; i++) begin
                rank = 4'h0;
                for (int j = 0; j < MAF_MED_TAPS; j++) begin
                    if (4'(j) < kk && (taps[j] < taps[i] || (taps[j] == taps[i] && j < i))) begin
                        rank = rank + 4'h1;
                    end
                end
                if (4'(i) < kk && rank == ((kk - 4'h1) >> 1)) begin
                    med_res = taps[i]; // RULE19
                end
            end
        end

        // Result selection; an inactive stage is a plain wire with a register
        always_comb begin
            case (maf_avg_t'(avg_type_q[gs]))
                MAF_AVG_MOVING: res = mov_res;
                MAF_AVG_RECURSIVE: res = rec_res;
                MAF_AVG_MEDIAN: res = med_res;
                default: res = stg_d[gs]; // RULE10
            endcase
        end

        // Window storage, no reset so it can map to RAM
        always_ff @(posedge clock_in) begin
            if (take) begin
                win_mem[wp_q] <= stg_d[gs];
            end
        end

        // Filter state; flush restarts at partial depth
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                wp_q <= '0;
                cnt_q <= 15'h0;
                sum_q <= '0;
                prev_q <= '0;
                for (int i = 0; i < MAF_MED_TAPS; i++) begin
                    tap_q[i] <= '0;
                end
            end else if (flush_q) begin
                wp_q <= '0;
                cnt_q <= 15'h0; // RULE1 RULE18
                sum_q <= '0;
            end else if (take) begin
                wp_q <= (wp_q == MAF_MOV_AW'(avg_depth_q[gs] - 15'h1)) ? '0 : wp_q + 1'b1;
                cnt_q <= k;
                sum_q <= sum_new;
                prev_q <= rec_res;
                for (int i = 0; i < MAF_MED_TAPS; i++) begin
                    tap_q[i] <= taps[i];
                end
            end
        end

        // One result per incoming sample unless flush_q drops it, invalid ones pass untouched
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                stg_v[gs+1] <= 1'b0;
                stg_ok[gs+1] <= 1'b0;
                stg_d[gs+1] <= '0;
            end else begin
                stg_v[gs+1] <= stg_v[gs] && !flush_q; // RULE8 RULE12
                stg_ok[gs+1] <= stg_ok[gs];
                stg_d[gs+1] <= stg_ok[gs] ? res : stg_d[gs]; // RULE8
            end
        end
    end

    // ==========================================================
    // Output with error handling; output trigger only gates release
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
            out_error_out <= 1'b0;
            analog_error_out <= 1'b0;
            last_q <= '0;
            have_last_q <= 1'b0;
            held_q <= 11'h0;
        end else begin
            out_valid_out <= 1'b0;
            if (stg_v[MAF_STAGES] && (!out_en_q || gate_q)) begin // RULE4 RULE12
                out_valid_out <= 1'b1;
                if (stg_ok[MAF_STAGES]) begin
                    out_data_out <= stg_d[MAF_STAGES];
                    out_error_out <= 1'b0;
                    analog_error_out <= 1'b0;
                    last_q <= stg_d[MAF_STAGES];
                    have_last_q <= 1'b1;
                    held_q <= 11'h0;
                end else if (have_last_q && (maf_err_t'(err_mode_q) == MAF_ERR_HOLD_INF ||
                             (maf_err_t'(err_mode_q) == MAF_ERR_HOLD_CNT && held_q < hold_cnt_q))) begin
                    out_data_out <= last_q; // RULE6 RULE7
                    out_error_out <= 1'b0;
                    analog_error_out <= 1'b0;
                    held_q <= (held_q < hold_cnt_q) ? held_q + 11'h1 : held_q;
                end else begin
                    out_data_out <= ERR_VALUE; // RULE5 RULE7
                    out_error_out <= 1'b1;
                    analog_error_out <= 1'b1; // RULE5
                end
            end
        end
    end

endmodule

// ===== verilog/maf_pkg.sv
// Purpose: Shared constants and types for the measurement averaging filter
// Assumes: Avalon-MM slave with 32-bit data, byte addresses on word boundaries
// Notes: Field positions and reset values are used by the filter top; the bench uses only the register map

package maf_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] MAF_REG_CTRL = 8'h00;
    localparam logic [7:0] MAF_REG_HOLD = 8'h04;
    localparam logic [7:0] MAF_REG_AVG1 = 8'h08;
    localparam logic [7:0] MAF_REG_AVG2 = 8'h0C;
    localparam logic [7:0] MAF_REG_STATUS = 8'h10;
    localparam logic [7:0] MAF_REG_RESULT = 8'h14;
    localparam logic [7:0] MAF_REG_SAVE = 8'h18;

    // ==========================================================
    // Field positions
    localparam int MAF_CTRL_REC_BIT = 0;
    localparam int MAF_CTRL_OUT_BIT = 1;
    localparam int MAF_CTRL_ERR_LSB = 2;
    localparam int MAF_CTRL_SWTRIG_BIT = 4;
    localparam int MAF_AVG_DEPTH_LSB = 0;
    localparam int MAF_AVG_TYPE_LSB = 16;
    localparam int MAF_STAT_GATE_BIT = 0;
    localparam int MAF_STAT_ERR_BIT = 1;
    localparam int MAF_STAT_HAVE_BIT = 2;

    // ==========================================================
    // Widths and limits
    localparam int MAF_DEPTH_W = 15;
    localparam int MAF_HOLD_W = 11;
    localparam int MAF_MOV_AW = 12;
    localparam int MAF_MED_TAPS = 9;
    localparam int MAF_STAGES = 2;
    localparam int MAF_CFG_W = MAF_DEPTH_W + 2;
    localparam int MAF_NVM_W = MAF_STAGES * MAF_CFG_W;
    localparam logic [14:0] MAF_MOV_MAX = 15'h1000;
    localparam logic [14:0] MAF_REC_MAX = 15'h7D00;
    localparam logic [10:0] MAF_HOLD_MAX = 11'h400;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {MAF_AVG_OFF, MAF_AVG_MOVING, MAF_AVG_RECURSIVE, MAF_AVG_MEDIAN} maf_avg_t;
    typedef enum logic [1:0] {MAF_ERR_VALUE, MAF_ERR_HOLD_INF, MAF_ERR_HOLD_CNT} maf_err_t;

    // ==========================================================
    // Reset values: first stage median over 9, second stage off
    localparam logic [1:0] MAF_RST_TYPE1 = 2'h3;
    localparam logic [14:0] MAF_RST_DEPTH1 = 15'h0009;
    localparam logic [1:0] MAF_RST_TYPE2 = 2'h0;
    localparam logic [14:0] MAF_RST_DEPTH2 = 15'h0001;
    localparam logic [10:0] MAF_RST_HOLD = 11'h001;

endpackage
